// ### logic/ie_codec_pkg.sv
package ie_codec_pkg;

    // Element identifiers
    localparam logic [7:0] ID_SEQ_NUM = 8'h00;
    localparam logic [7:0] ID_CAD_RING = 8'h01;
    localparam logic [7:0] ID_PULSED = 8'h02;
    localparam logic [7:0] ID_STEADY = 8'h03;

    // Content length values and bounds in octets
    localparam logic [7:0] LEN_FIXED_CONTENT = 8'h01;
    localparam logic [7:0] LEN_PULSED_MIN = 8'h01;
    localparam logic [7:0] LEN_PULSED_MAX = 8'h03;
    localparam int MAX_CONTENT = 3;

    // Field positions
    localparam int EXT_BIT = 7;
    localparam int IND_HI = 6;
    localparam int IND_LO = 5;
    localparam int FIELD5_HI = 4;

    // Pulse type range and examples
    localparam logic [6:0] PULSE_TYPE_MAX = 7'h7f;
    localparam logic [6:0] PULSE_TYPE_MIN = 7'h6b;
    localparam logic [6:0] PULSE_METER = 7'h78;

    // Steady-signal examples
    localparam logic [6:0] STEADY_LOOP_CLOSED = 7'h04;
    localparam logic [6:0] STEADY_STOP_RING = 7'h0e;
    localparam logic [6:0] STEADY_RAMP_NORMAL = 7'h1e;
    localparam logic [6:0] STEADY_MAX_ASSIGNED = 7'h1e;

    // Suppression indicator codes
    localparam logic [1:0] SUPP_NONE = 2'h0;
    localparam logic [1:0] SUPP_BY_MSG = 2'h1;
    localparam logic [1:0] SUPP_BY_LINE = 2'h2;
    localparam logic [1:0] SUPP_EITHER = 2'h3;

    // Acknowledge request codes
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_EACH_END = 2'h1;
    localparam logic [1:0] ACK_ALL_END = 2'h2;
    localparam logic [1:0] ACK_START = 2'h3;

    // Message kinds for sequence-number placement
    typedef enum logic [2:0] {
        MSG_SIGNAL = 3'h0,
        MSG_PROT_PARAM = 3'h1,
        MSG_SIGNAL_ACK = 3'h2,
        MSG_OTHER = 3'h3
    } msg_kind_e;

    typedef enum logic [1:0] {
        ELEM_SEQ = 2'h0,
        ELEM_RING = 2'h1,
        ELEM_PULSED = 2'h2,
        ELEM_STEADY = 2'h3
    } elem_kind_e;

    // Decoded or to-be-encoded element fields
    typedef struct packed {
        elem_kind_e kind;
        logic [6:0] value;      // sequence, cadence, pulse type or steady type
        logic hasOct4;
        logic hasOct4a;
        logic [1:0] suppress;
        logic [4:0] duration;
        logic [1:0] ackReq;
        logic [4:0] pulseCount;
    } ie_fields_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } octet_s;

endpackage

// ### logic/ie_len_check.sv
`timescale 1ns/100ps
module ie_len_check
    import ie_codec_pkg::*;
(
    input wire logic [7:0] ident,      // Element identifier
    input wire logic [7:0] lenOctet,   // Content length
    output logic known,                // Identifier handled here
    output logic lenOk                 // Length fits the element
);
    wire isFixed = (ident == ID_SEQ_NUM) || (ident == ID_CAD_RING) || (ident == ID_STEADY);
    wire isPulsed = (ident == ID_PULSED);
    assign known = isFixed || isPulsed;
    assign lenOk = (isFixed && lenOctet == LEN_FIXED_CONTENT) ||
                   (isPulsed && lenOctet >= LEN_PULSED_MIN && lenOctet <= LEN_PULSED_MAX);
endmodule

// ### logic/ie_content_check.sv
`timescale 1ns/100ps
module ie_content_check
    import ie_codec_pkg::*;
(
    input ie_fields_s fields,          // Fields to judge
    output logic pulseTypeOk,          // Pulse type in assigned range
    output logic steadyAssigned,       // Steady type is listed
    output logic countOk               // Pulse count nonzero when present
);
    assign pulseTypeOk = (fields.value <= PULSE_TYPE_MAX) && (fields.value >= PULSE_TYPE_MIN);
    // only 0x1b..0x1c are gaps below the top listed code
    assign steadyAssigned = (fields.value <= STEADY_MAX_ASSIGNED) && (fields.value != 7'h1b) &&
                            (fields.value != 7'h1c);
    assign countOk = !fields.hasOct4a || (fields.pulseCount != 5'h00);
endmodule

// ### logic/pstn_variable_ie_codec.sv
`timescale 1ns/100ps
module pstn_variable_ie_codec
    import ie_codec_pkg::*;
(
    input wire logic sys_clk,              // 125 MHz clock
    input wire logic srst,                 // Synchronous reset, active high
    input wire logic clkEn,                // Freezes all state when low
    input wire logic isExchangeSide,       // Device acts as exchange side
    // Encoder request
    input wire logic encStart,             // Start building an element
    output logic encReady,                 // Encoder idle
    input ie_fields_s encFields,           // Element to build
    input wire msg_kind_e encMsg,          // Message the element goes in
    input wire logic [6:0] sendSeq,        // Send sequence count
    input wire logic [6:0] recvSeq,        // Receive sequence count
    output octet_s txOct,                  // Built octet stream
    output logic encRefused,               // Request not permitted, pulse
    // Decoder stream
    input octet_s rxOct,                   // Received octet stream
    input wire msg_kind_e rxMsg,           // Message the stream belongs to
    output logic decDone,                  // Element decoded, pulse
    output ie_fields_s decFields,          // Decoded fields
    output logic decContentErr,            // Length or content conflict
    output logic decNotAllowed,            // Element not permitted here
    output logic decUnknown,               // Identifier not handled
    output logic decIsCommand,             // Element commands the line
    output logic seqMissing                // Held low; no logic ever raises it
);

    // ===========================================================
    // Encoder
    // ===========================================================
    typedef enum logic [2:0] {
        ENC_IDLE = 3'b000,
        ENC_ID = 3'b001,
        ENC_LEN = 3'b011,
        ENC_C3 = 3'b010,
        ENC_C4 = 3'b110,
        ENC_C4A = 3'b111
    } enc_state_e;

    enc_state_e encState_q, encState_d;
    ie_fields_s encHold_q;
    octet_s txOct_q, txOct_d;
    logic encRefused_q;

    wire isSeqReq = (encFields.kind == ELEM_SEQ);
    wire seqMsgOk = (encMsg == MSG_SIGNAL) || (encMsg == MSG_PROT_PARAM) || (encMsg == MSG_SIGNAL_ACK);
    wire ringBanned = (encFields.kind == ELEM_RING) && !isExchangeSide;
    wire zeroCount = (encFields.kind == ELEM_PULSED) && encFields.hasOct4 &&
                     encFields.hasOct4a && (encFields.pulseCount == 5'h00);
    wire seqBanned = isSeqReq && !seqMsgOk;
    wire encRefuse = ringBanned || zeroCount || seqBanned;
    wire encTake = encStart && (encState_q == ENC_IDLE);
    wire [6:0] seqPick = (encMsg == MSG_SIGNAL_ACK) ? recvSeq : sendSeq;

    ie_fields_s encLoad;
    always_comb begin
        encLoad = encFields;
        if (isSeqReq) begin
            encLoad.value = seqPick;
        end
        if (encFields.kind != ELEM_PULSED) begin
            encLoad.hasOct4 = 1'b0;
            encLoad.hasOct4a = 1'b0;
        end else if (!encFields.hasOct4) begin
            encLoad.hasOct4a = 1'b0;
        end
    end

    wire [7:0] encId = {6'h00, encHold_q.kind};
    wire [7:0] encLen = 8'h01 + {7'h00, encHold_q.hasOct4} + {7'h00, encHold_q.hasOct4a};
    wire [7:0] encOct3 = {1'b1, encHold_q.value};
    wire [7:0] encOct4 = {~encHold_q.hasOct4a, encHold_q.suppress, encHold_q.duration};
    wire [7:0] encOct4a = {1'b1, encHold_q.ackReq, encHold_q.pulseCount};

    always_comb begin
        encState_d = encState_q;
        txOct_d = '0;
        case (encState_q)
            ENC_IDLE: begin
                if (encTake && !encRefuse) begin
                    encState_d = ENC_ID;
                end
            end
            ENC_ID: begin
                txOct_d = '{valid: 1'b1, data: encId, last: 1'b0};
                encState_d = ENC_LEN;
            end
            ENC_LEN: begin
                txOct_d = '{valid: 1'b1, data: encLen, last: 1'b0};
                encState_d = ENC_C3;
            end
            ENC_C3: begin
                txOct_d = '{valid: 1'b1, data: encOct3, last: !encHold_q.hasOct4};
                encState_d = encHold_q.hasOct4 ? ENC_C4 : ENC_IDLE;
            end
            ENC_C4: begin
                txOct_d = '{valid: 1'b1, data: encOct4, last: !encHold_q.hasOct4a};
                encState_d = encHold_q.hasOct4a ? ENC_C4A : ENC_IDLE;
            end
            ENC_C4A: begin
                txOct_d = '{valid: 1'b1, data: encOct4a, last: 1'b1};
                encState_d = ENC_IDLE;
            end
            default: begin
                encState_d = ENC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            encState_q <= ENC_IDLE;
            encHold_q <= '0;
            txOct_q <= '0;
            encRefused_q <= 1'b0;
        end else if (clkEn) begin
            encState_q <= encState_d;
            txOct_q <= txOct_d;
            encRefused_q <= encTake && encRefuse;
            if (encTake) begin
                encHold_q <= encLoad;
            end
        end
    end

    assign encReady = (encState_q == ENC_IDLE);
    assign txOct = txOct_q;
    assign encRefused = encRefused_q;

    // ===========================================================
    // Decoder
    // ===========================================================
    logic [2:0] rxIdx_q;
    logic [7:0] rxId_q;
    logic [7:0] rxLen_q;
    ie_fields_s rxAcc_q, rxAcc_d;
    logic extSeen_q;
    logic seqSeen_q;
    logic decDone_q, decErr_q, decNa_q, decUnk_q, decCmd_q, seqMiss_q;
    ie_fields_s decFields_q;

    wire known;
    wire lenOk;
    ie_len_check u_ie_len_check (
        .ident(rxId_q),
        .lenOctet(rxLen_q),
        .known(known),
        .lenOk(lenOk)
    );

    wire pulseTypeOk;
    wire steadyAssigned;
    wire countOk;
    ie_content_check u_ie_content_check (
        .fields(rxAcc_d),
        .pulseTypeOk(pulseTypeOk),
        .steadyAssigned(steadyAssigned),
        .countOk(countOk)
    );

    wire rxTake = rxOct.valid;
    wire [2:0] contentCnt = (rxIdx_q >= 3'd2) ? rxIdx_q - 3'd1 : 3'd0;
    wire rxEnd = rxTake && rxOct.last;
    wire [1:0] rxKind = rxId_q[1:0];

    always_comb begin
        rxAcc_d = rxAcc_q;
        if (rxTake) begin
            case (rxIdx_q)
                3'd2: begin
                    rxAcc_d.kind = elem_kind_e'(rxKind);
                    rxAcc_d.value = rxOct.data[6:0];
                end
                3'd3: begin
                    rxAcc_d.hasOct4 = 1'b1;
                    rxAcc_d.suppress = rxOct.data[IND_HI:IND_LO];
                    rxAcc_d.duration = rxOct.data[FIELD5_HI:0];
                end
                3'd4: begin
                    rxAcc_d.hasOct4a = 1'b1;
                    rxAcc_d.ackReq = rxOct.data[IND_HI:IND_LO];
                    rxAcc_d.pulseCount = rxOct.data[FIELD5_HI:0];
                end
                default: begin
                    rxAcc_d = rxAcc_q;
                end
            endcase
        end
    end

    // Octet 4 extension 0 promises octet 4a; mismatches count as content errors
    // Ext bit of octet 4 is still on the wire when octet 4 is itself the last one
    wire ext4Bit = (rxIdx_q == 3'd3) ? rxOct.data[EXT_BIT] : extSeen_q;
    wire extConflict = rxAcc_d.hasOct4 && (ext4Bit == rxAcc_d.hasOct4a);
    wire lenMatch = (rxLen_q == {5'h00, contentCnt});
    wire isSeqId = known && (rxKind == ELEM_SEQ);
    wire rxSeqOk = (rxMsg == MSG_SIGNAL) || (rxMsg == MSG_PROT_PARAM) || (rxMsg == MSG_SIGNAL_ACK);
    wire contentBad = (rxKind == ELEM_PULSED && (!pulseTypeOk || !countOk)) ||
                      (rxKind == ELEM_STEADY && !steadyAssigned);
    wire errNow = known && (!lenOk || !lenMatch || extConflict || contentBad);
    wire ringWrongWay = known && (rxKind == ELEM_RING) && isExchangeSide;
    wire naNow = (isSeqId && !rxSeqOk) || ringWrongWay;
    // peer exchange commands the line, peer access reports it
    wire cmdNow = !isExchangeSide && (rxKind == ELEM_PULSED || rxKind == ELEM_STEADY || rxKind == ELEM_RING);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxIdx_q <= 3'd0;
            rxId_q <= '0;
            rxLen_q <= '0;
            rxAcc_q <= '0;
            extSeen_q <= 1'b1;
            seqSeen_q <= 1'b0;
            decDone_q <= 1'b0;
            decErr_q <= 1'b0;
            decNa_q <= 1'b0;
            decUnk_q <= 1'b0;
            decCmd_q <= 1'b0;
            seqMiss_q <= 1'b0;
            decFields_q <= '0;
        end else if (clkEn) begin
            decDone_q <= rxEnd;
            seqMiss_q <= 1'b0;
            if (rxTake) begin
                rxIdx_q <= rxOct.last ? 3'd0 : ((rxIdx_q == 3'd7) ? rxIdx_q : rxIdx_q + 3'd1);
                rxAcc_q <= rxOct.last ? '0 : rxAcc_d;
                if (rxIdx_q == 3'd0) begin
                    rxId_q <= rxOct.data;
                end
                if (rxIdx_q == 3'd1) begin
                    rxLen_q <= rxOct.data;
                end
                if (rxIdx_q == 3'd3) begin
                    extSeen_q <= rxOct.data[EXT_BIT];
                end else if (rxOct.last) begin
                    extSeen_q <= 1'b1;
                end
            end
            if (rxEnd) begin
                decFields_q <= rxAcc_d;
                decErr_q <= errNow;
                decNa_q <= naNow;
                decUnk_q <= !known;
                decCmd_q <= cmdNow;
                if (isSeqId) begin
                    seqSeen_q <= 1'b1;
                end
            end
            // Message boundary: an idle MSG_OTHER cycle clears seqSeen_q; nothing reports a missing element
            if (rxOct.valid == 1'b0 && rxIdx_q == 3'd0 && rxMsg == MSG_OTHER) begin
                seqSeen_q <= 1'b0;
            end
        end
    end

    assign decDone = decDone_q;
    assign decFields = decFields_q;
    assign decContentErr = decErr_q;
    assign decNotAllowed = decNa_q;
    assign decUnknown = decUnk_q;
    assign decIsCommand = decCmd_q;
    assign seqMissing = seqMiss_q;

    // ===========================================================
    // Checks
    // ===========================================================
    AST_FIXED_LEN: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encState_q == ENC_LEN && !encHold_q.hasOct4) |-> (encLen == 8'h01))
        else $error("fixed element length not one content octet");
    AST_PULSED_LEN: assert property (@(posedge sys_clk) disable iff (srst)
        (encState_q == ENC_LEN) |-> (encLen >= LEN_PULSED_MIN && encLen <= LEN_PULSED_MAX))
        else $error("pulsed length out of range");
    AST_NO_RING_FROM_ACCESS: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encTake && encFields.kind == ELEM_RING && !isExchangeSide) |=> (encRefused && encReady))
        else $error("access side began a ringing element");
    AST_NO_ZERO_COUNT: assert property (@(posedge sys_clk) disable iff (srst)
        (txOct.valid && encState_q == ENC_IDLE && txOct.last && encHold_q.hasOct4a) |-> (txOct.data[4:0] != 5'h00))
        else $error("zero pulse count emitted");
    AST_SEQ_PLACE: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encTake && isSeqReq && !seqMsgOk) |=> encRefused ##1 !txOct.valid)
        else $error("sequence element in wrong message");
    AST_EXT_BIT: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encState_q == ENC_C3) |=> (txOct.valid && txOct.data[EXT_BIT]))
        else $error("octet 3 extension bit not one");
    AST_OCT4_EXT: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encState_q == ENC_C4) |=> (txOct.data[EXT_BIT] == !encHold_q.hasOct4a))
        else $error("octet 4 extension does not announce octet 4a");
    AST_SEQ_COUNT: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encTake && !encRefuse && isSeqReq) |=> (encHold_q.value == $past(seqPick)))
        else $error("wrong sequence count latched");
    AST_LEN_ERR: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && !lenOk) |=> (decDone && decContentErr))
        else $error("length conflict not flagged");
    AST_TX_ID_FIRST: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && encState_q == ENC_ID) |=> (txOct.valid && !txOct.last && txOct.data == encId))
        else $error("identifier octet not sent first");
    AST_SEQ_NOT_ALLOWED: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && isSeqId && !rxSeqOk) |=> (decDone && decNotAllowed))
        else $error("sequence element in wrong message not flagged");
    AST_SEQ_DEC_VALUE: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && isSeqId && rxIdx_q == 3'd2) |=> (decFields.value == $past(rxOct.data[6:0])))
        else $error("decoded sequence value differs from octet 3");
    AST_PULSE_TYPE: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && rxKind == ELEM_PULSED && !pulseTypeOk) |=> decContentErr)
        else $error("unlisted pulse type not flagged");
    AST_ZERO_COUNT_ERR: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && rxKind == ELEM_PULSED && !countOk) |=> decContentErr)
        else $error("zero pulse count not flagged");
    AST_STEADY_UNASSIGNED: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && rxKind == ELEM_STEADY && !steadyAssigned) |=> decContentErr)
        else $error("unassigned steady type not flagged");
    AST_EXT_CONFLICT: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && extConflict) |=> decContentErr)
        else $error("octet 4 extension conflict not flagged");
    AST_CMD_DIR: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && known && rxKind == ELEM_STEADY) |=> (decIsCommand != $past(isExchangeSide)))
        else $error("steady element direction misjudged");
    AST_UNKNOWN_ID: assert property (@(posedge sys_clk) disable iff (srst)
        (clkEn && rxEnd && !known) |=> (decUnknown && !decContentErr))
        else $error("unknown identifier not flagged");

endmodule

// ### tb/peer_entity.sv
`timescale 1ns/100ps
// ============================================================
// Far-side signalling peer
module peer_entity
    import ie_codec_pkg::*;
(
    input wire logic sys_clk,   // Shared clock
    input wire logic devIsExch, // Device acts as exchange side
    input octet_s txOct,        // Octets built by the device
    output octet_s rxOct        // Octets sent toward the device
);
    logic [8:0] capQ[$];

    initial rxOct = '0;

    always @(posedge sys_clk) begin
        if (txOct.valid) begin
            capQ.push_back({txOct.last, txOct.data});
        end
    end

    // Idle data is the inverse of the last octet, so a stale octet never looks valid
    task automatic sendElem(input logic [0:4][7:0] o, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            // Side is read a cycle after the caller sets it, never in the same step
            if (devIsExch && o[0] == ID_CAD_RING) begin
                return;
            end
            rxOct <= '{1'b1, o[i], i == n - 1};
            @(posedge sys_clk);
            for (int g = 0; g < gap && i < n - 1; g++) begin
                @(negedge sys_clk);
                rxOct <= '{1'b0, ~o[i], 1'b0};
                @(posedge sys_clk);
            end
        end
        @(negedge sys_clk);
        rxOct <= '{1'b0, ~o[n - 1], 1'b0};
    endtask
endmodule

// ### tb/pstn_variable_ie_codec_tb_top.sv
`timescale 1ns/100ps
module pstn_variable_ie_codec_tb_top
    import ie_codec_pkg::*;
;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic isExchangeSide = 1'b1;
    logic encStart = 1'b0;
    logic encReady, encRefused, decDone, decContentErr, decNotAllowed, decUnknown, decIsCommand, seqMissing;
    ie_fields_s encFields = '0;
    ie_fields_s decFields;
    msg_kind_e encMsg = MSG_SIGNAL;
    msg_kind_e rxMsg = MSG_SIGNAL;
    logic [6:0] sendSeq = 7'h5a;
    logic [6:0] recvSeq = 7'h23;
    octet_s txOct, rxOct;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    pstn_variable_ie_codec u_pstn_variable_ie_codec (
        .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .isExchangeSide(isExchangeSide),
        .encStart(encStart), .encReady(encReady), .encFields(encFields), .encMsg(encMsg),
        .sendSeq(sendSeq), .recvSeq(recvSeq), .txOct(txOct), .encRefused(encRefused),
        .rxOct(rxOct), .rxMsg(rxMsg), .decDone(decDone), .decFields(decFields),
        .decContentErr(decContentErr), .decNotAllowed(decNotAllowed), .decUnknown(decUnknown),
        .decIsCommand(decIsCommand), .seqMissing(seqMissing));

    peer_entity u_peer_entity (.sys_clk(sys_clk), .devIsExch(isExchangeSide), .txOct(txOct), .rxOct(rxOct));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Ceiling is several times the length of the full run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ============================================================
    // Shared helpers
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic ie_fields_s mk(input elem_kind_e k, input logic [6:0] v, input logic h4, input logic h4a,
        input logic [1:0] s, input logic [4:0] d, input logic [1:0] a, input logic [4:0] c);
        return '{k, v, h4, h4a, s, d, a, c};
    endfunction

    // A count of zero expects a refusal and no octets at all
    task automatic encode(input ie_fields_s f, input msg_kind_e m, input logic [0:4][7:0] exp, input int n);
        logic seen;
        @(negedge sys_clk);
        u_peer_entity.capQ.delete();
        encFields <= f;
        encMsg <= m;
        encStart <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        encStart <= 1'b0;
        // Refusal pulse stands only in the cycle right after the take
        seen = encRefused === 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            seen |= encRefused === 1'b1;
            if (n > 0 && u_peer_entity.capQ.size() == n) break;
        end
        chk("encRefused", n == 0, seen);
        chk("octet count", n, u_peer_entity.capQ.size());
        for (int i = 0; i < n; i++) chk("tx octet", {i == n - 1, exp[i]}, u_peer_entity.capQ[i]);
        chk("encReady", 1, encReady);
    endtask

    task automatic decode(input logic [0:4][7:0] o, input int n, input int gap, input msg_kind_e m,
        input logic exch, input logic [3:0] flags, input ie_fields_s expF, input logic [24:0] mask);
        logic seen;
        @(negedge sys_clk);
        rxMsg <= m;
        isExchangeSide <= exch;
        u_peer_entity.sendElem(o, n, gap);
        // The peer returns on the falling edge while decDone stands
        seen = decDone === 1'b1;
        for (int i = 0; i < 8 && !seen; i++) begin
            @(negedge sys_clk);
            seen = decDone === 1'b1;
        end
        chk("decDone", 1, seen);
        chk("dec flags", flags, {decContentErr, decNotAllowed, decUnknown, decIsCommand});
        chk("dec fields", expF & mask, decFields & mask);
        chk("seqMissing", 0, seqMissing);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_seq();
        isExchangeSide <= 1'b0;
        encode(mk(ELEM_SEQ, 0, 0, 0, 0, 0, 0, 0), MSG_SIGNAL, {ID_SEQ_NUM, 8'h01, 1'b1, sendSeq, 16'h0}, 3);
        encode(mk(ELEM_SEQ, 0, 0, 0, 0, 0, 0, 0), MSG_PROT_PARAM, {ID_SEQ_NUM, 8'h01, 1'b1, sendSeq, 16'h0}, 3);
        encode(mk(ELEM_SEQ, 0, 0, 0, 0, 0, 0, 0), MSG_SIGNAL_ACK, {ID_SEQ_NUM, 8'h01, 1'b1, recvSeq, 16'h0}, 3);
        encode(mk(ELEM_SEQ, 0, 0, 0, 0, 0, 0, 0), MSG_OTHER, 40'h0, 0);
    endtask

    task automatic t_ring();
        isExchangeSide <= 1'b1;
        encode(mk(ELEM_RING, 7'h05, 0, 0, 0, 0, 0, 0), MSG_SIGNAL, {ID_CAD_RING, 8'h01, 8'h85, 16'h0}, 3);
        isExchangeSide <= 1'b0;
        encode(mk(ELEM_RING, 7'h05, 0, 0, 0, 0, 0, 0), MSG_SIGNAL, 40'h0, 0);
    endtask

    task automatic t_pulsed();
        logic [6:0] types [4] = '{PULSE_TYPE_MAX, PULSE_METER, PULSE_TYPE_MIN, 7'h70};
        isExchangeSide <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            encode(mk(ELEM_PULSED, types[k], 1, 1, k[1:0], 5'h1f - k[4:0], 2'h3 - k[1:0], 5'h1f >> k), MSG_SIGNAL,
                {ID_PULSED, 8'h03, 1'b1, types[k], 1'b0, k[1:0], 5'h1f - k[4:0], 1'b1, 2'h3 - k[1:0],
                5'h1f >> k}, 5);
        end
        encode(mk(ELEM_PULSED, PULSE_METER, 0, 0, 0, 0, 0, 0), MSG_SIGNAL, {ID_PULSED, 8'h01, 1'b1, PULSE_METER, 16'h0}, 3);
        encode(mk(ELEM_PULSED, PULSE_METER, 1, 0, SUPP_EITHER, 5'h0a, 0, 0), MSG_SIGNAL,
            {ID_PULSED, 8'h02, 1'b1, PULSE_METER, 1'b1, SUPP_EITHER, 5'h0a, 8'h0}, 4);
        encode(mk(ELEM_PULSED, PULSE_METER, 1, 1, 0, 5'h01, ACK_NONE, 5'h00), MSG_SIGNAL, 40'h0, 0);
    endtask

    task automatic t_steady();
        logic [6:0] codes [3] = '{STEADY_LOOP_CLOSED, STEADY_STOP_RING, STEADY_RAMP_NORMAL};
        for (int k = 0; k < 3; k++) begin
            encode(mk(ELEM_STEADY, codes[k], 0, 0, 0, 0, 0, 0), MSG_SIGNAL,
                {ID_STEADY, 8'h01, 1'b1, codes[k], 16'h0}, 3);
        end
    endtask

    task automatic t_decode();
        decode({ID_PULSED, 8'h03, 1'b1, PULSE_METER, 1'b0, SUPP_BY_LINE, 5'h05, 1'b1, ACK_ALL_END, 5'h09}, 5, 2,
            MSG_SIGNAL, 1, 4'h0, mk(ELEM_PULSED, PULSE_METER, 1, 1, SUPP_BY_LINE, 5'h05, ACK_ALL_END, 5'h09),
            25'h1ffffff);
        decode({ID_STEADY, 8'h01, 1'b1, STEADY_STOP_RING, 16'h0}, 3, 0, MSG_SIGNAL, 0, 4'h1,
            mk(ELEM_STEADY, STEADY_STOP_RING, 0, 0, 0, 0, 0, 0), 25'h1ff0000);
        decode({ID_STEADY, 8'h01, 1'b1, STEADY_LOOP_CLOSED, 16'h0}, 3, 0, MSG_SIGNAL, 1, 4'h0,
            mk(ELEM_STEADY, STEADY_LOOP_CLOSED, 0, 0, 0, 0, 0, 0), 25'h1ff0000);
        decode({ID_CAD_RING, 8'h01, 8'h85, 16'h0}, 3, 0, MSG_SIGNAL, 0, 4'h1,
            mk(ELEM_RING, 7'h05, 0, 0, 0, 0, 0, 0), 25'h1ff0000);
        decode({ID_SEQ_NUM, 8'h01, 8'h91, 16'h0}, 3, 0, MSG_SIGNAL_ACK, 1, 4'h0,
            mk(ELEM_SEQ, 7'h11, 0, 0, 0, 0, 0, 0), 25'h1ff0000);
        decode({ID_SEQ_NUM, 8'h01, 8'h91, 16'h0}, 3, 0, MSG_OTHER, 1, 4'h4, '0, '0);
        decode({ID_SEQ_NUM, 8'h02, 8'h91, 8'h81, 8'h0}, 4, 0, MSG_SIGNAL, 1, 4'h8, '0, '0);
        decode({ID_PULSED, 8'h03, 1'b1, PULSE_METER, 8'h05, 8'h80}, 5, 0, MSG_SIGNAL, 1, 4'h8, '0, '0);
        decode({ID_PULSED, 8'h02, 1'b1, PULSE_METER, 8'h05, 8'h0}, 4, 0, MSG_SIGNAL, 1, 4'h8, '0, '0);
        decode({8'h04, 8'h01, 8'h81, 16'h0}, 3, 0, MSG_SIGNAL, 1, 4'h2, '0, '0);
        decode({ID_STEADY, 8'h01, 8'h9b, 16'h0}, 3, 0, MSG_SIGNAL, 1, 4'h8, '0, '0);
        decode({ID_STEADY, 8'h01, 8'h90, 16'h0}, 3, 0, MSG_SIGNAL, 1, 4'h0,
            mk(ELEM_STEADY, 7'h10, 0, 0, 0, 0, 0, 0), 25'h1ff0000);
    endtask

    // A request held while the clock enable is low must not start the encoder
    task automatic t_freeze();
        @(negedge sys_clk);
        u_peer_entity.capQ.delete();
        clkEn <= 1'b0;
        encFields <= mk(ELEM_STEADY, STEADY_STOP_RING, 0, 0, 0, 0, 0, 0);
        encMsg <= MSG_SIGNAL;
        encStart <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("frozen octets", 0, u_peer_entity.capQ.size());
        chk("frozen encReady", 1, encReady);
        encStart <= 1'b0;
        clkEn <= 1'b1;
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge sys_clk);
        srst <= 1'b0;
        t_seq();
        t_ring();
        t_pulsed();
        t_freeze();
        t_steady();
        t_decode();
        end_of_test();
    end
endmodule
